// [logic/fgp_in_bit.sv]
// One input data bit with freeze and gating
`timescale 1ns/1ns
`default_nettype none
module fgp_in_bit
	import fgp_pkg::*;
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	// Pin and qualifiers
	input  wire logic i_pin,
	input  wire logic i_impl,
	input  wire logic i_digital,
	input  wire logic i_ctl_en,
	input  wire logic i_in_off,
	// Sampled level
	output logic      o_q
);
	logic lvl_q;

	// Sample the pin, zero when gated, hold when frozen
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			lvl_q <= 1'b0;
		else if (!i_impl || !i_digital || i_in_off)
			lvl_q <= 1'b0;
		else if (i_ctl_en)
			lvl_q <= i_pin;
	end

	assign o_q = lvl_q;
endmodule : fgp_in_bit
`default_nettype wire

// [logic/fgp_out_bit.sv]
// One output data bit with set, clear and toggle update
`timescale 1ns/1ns
`default_nettype none
module fgp_out_bit
	import fgp_pkg::*;
#(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	// Update controls
	input  wire logic i_wr_data,
	input  wire logic i_wr_bit,
	input  wire logic i_set,
	input  wire logic i_clr,
	input  wire logic i_tgl,
	input  wire logic i_impl,
	// Stored level
	output logic      o_q
);
	logic bit_q;
	logic bit_d;

	// Next value by the kind of write
	always_comb begin
		bit_d = bit_q;
		if (i_wr_data)
			bit_d = i_wr_bit;
		else if (i_set && i_wr_bit)
			bit_d = 1'b1;
		else if (i_clr && i_wr_bit)
			bit_d = 1'b0;
		else if (i_tgl && i_wr_bit)
			bit_d = ~bit_q;
		if (!i_impl)
			bit_d = 1'b0;
	end

	// Storage
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			bit_q <= RST_VAL;
		else
			bit_q <= bit_d;
	end

	assign o_q = bit_q;
endmodule : fgp_out_bit
`default_nettype wire

// [logic/fgp_pkg.sv]
// Package for the fast GPIO port register block
// Overview of operation
// - Each pin is driven to its output data bit only while its direction selects output.
// - Output data bits of unimplemented pins read as zero.
// - A write to the set port forces to 1 each output data bit written as 1.
// - A write to the clear port forces to 0 each output data bit written as 1.
// - A write to the toggle port inverts each output data bit written as 1.
// - Set, clear and toggle writes leave bits written as 0 unchanged.
// - Each input data bit holds the sampled level of its pin.
// - Input data bits of unimplemented pins read as zero.
// - Input data bits of pins with no digital function read as zero.
// - An input data bit does not sample its pin while its port control is disabled.
// - A clear direction bit means input and a set one means output.
// - A pin set as input with its input disabled is left undriven.
// - Input is enabled on a pin whose input-disable bit and direction bit are 0 and that has a digital function.
// - A set input-disable bit disables input and its input data bit reads zero.
// - Valid accesses finish with no wait state and erroneous ones with one.
// - Any access outside the register map signals a bus error.
`default_nettype none
package fgp_pkg;
	localparam int unsigned FGP_DW = 32;
	localparam int unsigned FGP_AW = 8;
	localparam logic [7:0] FGP_OFS_DATA_OUT = 8'h00;
	localparam logic [7:0] FGP_OFS_SET      = 8'h04;
	localparam logic [7:0] FGP_OFS_CLEAR    = 8'h08;
	localparam logic [7:0] FGP_OFS_TOGGLE   = 8'h0c;
	localparam logic [7:0] FGP_OFS_DATA_IN  = 8'h10;
	localparam logic [7:0] FGP_OFS_DIR      = 8'h14;
	localparam logic [7:0] FGP_OFS_IN_OFF   = 8'h18;
	localparam logic [31:0] FGP_RST_DATA_OUT = 32'h0000_0000;
	localparam logic [31:0] FGP_RST_DIR      = 32'h0000_0000;
	localparam logic [31:0] FGP_RST_IN_OFF   = 32'hffff_ffff;
	localparam logic [31:0] FGP_RST_DATA_IN  = 32'h0000_0000;
	localparam logic [31:0] FGP_IMPL_DEFAULT = 32'hffff_ffff;
	// Bus request from the core
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} fgp_req_t;
	// Answer to the core
	typedef struct packed {
		logic        ready;
		logic        error;
		logic [31:0] rdata;
	} fgp_rsp_t;
	// Decoded access kind
	typedef enum logic [2:0] {
		FGP_K_NONE, FGP_K_DOUT, FGP_K_SET, FGP_K_CLR,
		FGP_K_TGL, FGP_K_DIN, FGP_K_DIR, FGP_K_INOFF
	} fgp_kind_t;
endpackage : fgp_pkg
`default_nettype wire

// [logic/fgp_port.sv]
// Fast GPIO port register block on the core local bus
`timescale 1ns/1ns
`default_nettype none
module fgp_port
	import fgp_pkg::*;
#(
	parameter int unsigned NPINS = 32,
	parameter logic [31:0] IMPL_MASK = FGP_IMPL_DEFAULT
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	// Core local bus
	input  wire fgp_req_t i_req,
	output fgp_rsp_t      o_rsp,
	// Port control side
	input  wire logic [NPINS-1:0] i_digital,
	input  wire logic [NPINS-1:0] i_ctl_en,
	// Pins
	input  wire logic [NPINS-1:0] i_pin,
	output logic      [NPINS-1:0] o_pin,
	output logic      [NPINS-1:0] o_pin_oe_n,
	output logic      [NPINS-1:0] o_pin_in_en
);
	fgp_kind_t         kind;
	logic              bad;
	logic [NPINS-1:0]  dout;
	logic [NPINS-1:0]  din;
	logic [NPINS-1:0]  dir_q;
	logic [NPINS-1:0]  in_off_q;
	logic              err_q;
	logic [31:0]       rdata_d;
	logic [NPINS-1:0]  wbits;

	assign wbits = i_req.wdata[NPINS-1:0];

	// Address decode
	always_comb begin
		kind = FGP_K_NONE;
		bad  = 1'b0;
		if (i_req.valid) begin
			case (i_req.addr)
				FGP_OFS_DATA_OUT: kind = FGP_K_DOUT;
				FGP_OFS_SET:      kind = FGP_K_SET;
				FGP_OFS_CLEAR:    kind = FGP_K_CLR;
				FGP_OFS_TOGGLE:   kind = FGP_K_TGL;
				FGP_OFS_DATA_IN:  kind = FGP_K_DIN;
				FGP_OFS_DIR:      kind = FGP_K_DIR;
				FGP_OFS_IN_OFF:   kind = FGP_K_INOFF;
				default:          bad  = 1'b1;
			endcase
		end
	end

	// Per-pin output and input bits
	for (genvar g = 0; g < NPINS; g++) begin : g_pin
		fgp_out_bit #(
			.RST_VAL (FGP_RST_DATA_OUT[g])
		) u_out (
			.i_clk     (i_clk),
			.i_sys_rst (i_sys_rst),
			.i_wr_data (i_req.write && kind == FGP_K_DOUT),
			.i_wr_bit  (wbits[g]),
			.i_set     (i_req.write && kind == FGP_K_SET),
			.i_clr     (i_req.write && kind == FGP_K_CLR),
			.i_tgl     (i_req.write && kind == FGP_K_TGL),
			.i_impl    (IMPL_MASK[g]),
			.o_q       (dout[g])
		);
		fgp_in_bit u_in (
			.i_clk     (i_clk),
			.i_sys_rst (i_sys_rst),
			.i_pin     (i_pin[g]),
			.i_impl    (IMPL_MASK[g]),
			.i_digital (i_digital[g]),
			.i_ctl_en  (i_ctl_en[g]),
			.i_in_off  (in_off_q[g]),
			.o_q       (din[g])
		);
	end

	// Direction register
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			dir_q <= FGP_RST_DIR[NPINS-1:0];
		else if (i_req.write && kind == FGP_K_DIR)
			dir_q <= wbits & IMPL_MASK[NPINS-1:0];
	end

	// Input disable register
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			in_off_q <= FGP_RST_IN_OFF[NPINS-1:0];
		else if (i_req.write && kind == FGP_K_INOFF)
			in_off_q <= wbits;
	end

	// Pin drive: direction picks output, else undriven
	always_comb begin
		o_pin       = dout;
		o_pin_oe_n  = ~dir_q;
		o_pin_in_en = ~in_off_q & i_digital & ~dir_q;
	end

	// Read data mux
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (kind)
			FGP_K_DOUT:  rdata_d[NPINS-1:0] = dout;
			FGP_K_DIN:   rdata_d[NPINS-1:0] = din;
			FGP_K_DIR:   rdata_d[NPINS-1:0] = dir_q;
			FGP_K_INOFF: rdata_d[NPINS-1:0] = in_off_q;
			default:     rdata_d = 32'h0000_0000;
		endcase
	end

	// Error wait state tracking
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			err_q <= 1'b0;
		else
			err_q <= bad && !err_q;
	end

	// Valid access ready at once; error ready after one wait
	always_comb begin
		o_rsp.ready = (i_req.valid && !bad) || err_q;
		o_rsp.error = err_q;
		o_rsp.rdata = rdata_d;
	end

	// Checks
	AST_ZERO_WAIT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_req.valid && !bad |-> o_rsp.ready && !o_rsp.error)
		else $error("valid access not answered at once");
	AST_ERR_ONE_WAIT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		bad && !err_q |-> !o_rsp.ready ##1 (o_rsp.ready && o_rsp.error))
		else $error("error access not one wait state");
	AST_SET: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_req.valid && i_req.write && i_req.addr == FGP_OFS_SET
		|=> (dout & $past(wbits) & IMPL_MASK[NPINS-1:0])
			== ($past(wbits) & IMPL_MASK[NPINS-1:0]))
		else $error("set port did not set bits");
	AST_CLR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_req.valid && i_req.write && i_req.addr == FGP_OFS_CLEAR
		|=> (dout & $past(wbits)) == '0)
		else $error("clear port did not clear bits");
	AST_TGL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_req.valid && i_req.write && i_req.addr == FGP_OFS_TOGGLE
		|=> dout == (($past(dout) ^ $past(wbits))
			& IMPL_MASK[NPINS-1:0]))
		else $error("toggle port wrong result");
	AST_WO_READ0: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_req.valid && !i_req.write && (i_req.addr == FGP_OFS_SET
			|| i_req.addr == FGP_OFS_CLEAR || i_req.addr == FGP_OFS_TOGGLE)
		|-> o_rsp.rdata == 32'h0000_0000)
		else $error("write-only port read nonzero");
	AST_DOUT_IMPL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(dout & ~IMPL_MASK[NPINS-1:0]) == '0)
		else $error("unimplemented output bit set");
	AST_IN_OFF_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(in_off_q | ~i_digital) != '0 |=>
			(din & $past(in_off_q | ~i_digital)) == '0)
		else $error("gated input bit not zero");
	AST_FREEZE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(~i_ctl_en & ~in_off_q & i_digital) != '0 |=>
			((din ^ $past(din)) & $past(~i_ctl_en & ~in_off_q
				& i_digital)) == '0)
		else $error("frozen input bit changed");
	AST_SAMPLE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		1'b1 |=> ((din ^ $past(i_pin)) & $past(i_ctl_en & ~in_off_q
			& i_digital) & IMPL_MASK[NPINS-1:0]) == '0)
		else $error("input bit not pin level");
	AST_DRIVE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_pin_oe_n == ~dir_q && (o_pin_in_en & dir_q) == '0)
		else $error("pin drive does not follow direction");
endmodule : fgp_port
`default_nettype wire

// [sim/fgp_pin_env.sv]
// Pad model: resolves each pin from the port and an outside driver
`timescale 1ns/1ns
`default_nettype none
module fgp_pin_env (
	// Clock
	input  wire logic        i_clk,
	// Port side
	input  wire logic [31:0] i_level,
	input  wire logic [31:0] i_oe_n,
	// Outside driver
	input  wire logic [31:0] i_ext,
	input  wire logic [31:0] i_ext_en,
	// Resolved pins
	output logic      [31:0] o_pin
);
	logic [31:0] float_q;

	// Undriven pads start from a fixed pattern
	initial float_q = 32'h5555_5555;

	// Undriven pads wander every cycle, never a stale level
	always @(posedge i_clk) begin
		float_q <= ~float_q;
	end

	// Port drives while its enable is low, else outside or floating
	assign o_pin = (~i_oe_n & i_level) | (i_oe_n & i_ext_en & i_ext)
		| (i_oe_n & ~i_ext_en & float_q);
endmodule : fgp_pin_env
`default_nettype wire

// [sim/fgp_port_tb_top.sv]
// Testbench for the fast GPIO port register block
`timescale 1ns/1ns
`default_nettype none
module fgp_port_tb_top;
	import fgp_pkg::*;
	localparam logic [31:0] IMPL = 32'h00ff_ffff;
	logic        i_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	fgp_req_t    i_req = '0;
	fgp_rsp_t    o_rsp;
	fgp_rsp_t    rsp;
	logic [31:0] dig = '1;
	logic [31:0] ctl = '1;
	logic [31:0] ext = '0;
	logic [31:0] pin;
	logic [31:0] o_pin;
	logic [31:0] oe_n;
	logic [31:0] in_en;
	logic [31:0] od;
	logic [31:0] dir;
	logic [31:0] inoff;
	logic [31:0] m;
	logic [31:0] e;
	logic [7:0]  ofs [3] = '{FGP_OFS_SET, FGP_OFS_CLEAR, FGP_OFS_TOGGLE};
	int          n_errors = 0;
	int          n_tests = 0;
	int          waits;

	// Clock
	always #20 i_clk = ~i_clk;

	fgp_port #(.NPINS(32), .IMPL_MASK(IMPL)) fgp_port_inst (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .o_rsp(o_rsp),
		.i_digital(dig), .i_ctl_en(ctl), .i_pin(pin), .o_pin(o_pin),
		.o_pin_oe_n(oe_n), .o_pin_in_en(in_en));
	fgp_pin_env fgp_pin_env_inst (
		.i_clk(i_clk), .i_level(o_pin), .i_oe_n(oe_n), .i_ext(ext),
		.i_ext_en(32'hffff_ffff), .o_pin(pin));

	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One access, held until ready is seen just before an edge
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		i_req = '{valid: 1'b1, write: w, addr: a, wdata: d};
		for (k = 0; k < 4; k++) begin
			#38;
			rsp = o_rsp;
			@(posedge i_clk);
			#1;
			if (rsp.ready === 1'b1)
				break;
		end
		waits = k;
		if (k == 4) begin
			n_errors++;
			give_verdict();
		end
	endtask : acc

	task rd(input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(rsp.rdata, exp);
	endtask : rd

	task idle;
		i_req.valid = 1'b0;
		@(posedge i_clk);
		#1;
	endtask : idle

	// Let pins settle, then read input bits of input pins
	task rd_in(input logic [31:0] exp);
		idle();
		idle();
		acc(1'b0, FGP_OFS_DATA_IN, 32'h0);
		chk(rsp.rdata & ~dir, exp & ~dir);
	endtask : rd_in

	// Main sequence
	initial begin
		repeat (10) @(posedge i_clk);
		#1 i_sys_rst = 1'b0;
		rd(FGP_OFS_DATA_OUT, FGP_RST_DATA_OUT);
		rd(FGP_OFS_DIR, FGP_RST_DIR);
		rd(FGP_OFS_IN_OFF, FGP_RST_IN_OFF);
		rd(FGP_OFS_DATA_IN, 32'h0);
		chk(oe_n, 32'hffff_ffff);
		$display("test reset done");
		od = 32'ha5a5_a5a5;
		acc(1'b1, FGP_OFS_DATA_OUT, od);
		for (int i = 0; i < 3; i++) begin
			m = 32'h3c3c_0ff0 << i;
			acc(1'b1, ofs[i], m);
			chk({rsp.error, 31'(waits)}, 32'h0);
			od = (i == 0) ? od | m : (i == 1) ? od & ~m : od ^ m;
			rd(FGP_OFS_DATA_OUT, od & IMPL);
			rd(ofs[i], 32'h0);
		end
		$display("test bit updates done");
		dir = 32'h00ff_00ff;
		inoff = 32'h0;
		ext = 32'h5a5a_c3c3;
		acc(1'b1, FGP_OFS_DIR, dir);
		acc(1'b1, FGP_OFS_IN_OFF, inoff);
		rd(FGP_OFS_DIR, dir & IMPL);
		chk(oe_n & IMPL, ~dir & IMPL);
		chk(pin & dir & IMPL, od & dir & IMPL);
		rd_in(ext & IMPL);
		chk(in_en & IMPL, ~dir & IMPL);
		dig = 32'hffff_fcff;
		inoff = 32'h0000_0c00;
		acc(1'b1, FGP_OFS_IN_OFF, inoff);
		e = ext & dig & ~inoff & IMPL;
		rd_in(e);
		chk(oe_n & inoff, inoff);
		chk(in_en & IMPL, ~inoff & dig & ~dir & IMPL);
		ctl = 32'hffff_cfff;
		ext = ~ext;
		e = (ext & dig & ~inoff & IMPL & ctl) | (e & ~ctl);
		rd_in(e);
		$display("test pins done");
		acc(1'b1, 8'h1c, 32'hffff_ffff);
		chk({rsp.error, 31'(waits)}, {1'b1, 31'd1});
		acc(1'b0, 8'h40, 32'h0);
		chk({rsp.error, 31'(waits)}, {1'b1, 31'd1});
		acc(1'b1, FGP_OFS_DATA_IN, 32'hffff_ffff);
		rd(FGP_OFS_DATA_OUT, od & IMPL);
		rd_in(e);
		$display("test bad access done");
		give_verdict();
	end
endmodule : fgp_port_tb_top
`default_nettype wire
